// [cfs_pkg.sv]
// Function
// R01 - input faults cut rail and charging, timer paused
// R02 - battery-side faults keep rail, stop charging
// R03 - undervoltage or timer fault clears safety timer
// R04 - safety timer runs throughout a charge cycle
// R05 - timer expiry suspends charge, pulses, logs fault
// R06 - host selects safety timer duration over bus
// R07 - fifteen second watchdog restarted by bus writes
// R08 - guard enable zero stops, one restarts watchdog
// R09 - watchdog expiry loads defaults, charging continues
// R10 - host mode restorable only before timer expiry
// R11 - die heat limit tapers charge current
// R12 - overheat trip stops all, pulses, logs fault
// R13 - recovery after cooling starts new charge cycle
// R14 - sticky read-only watchdog timeout flag, bit seven
// R15 - phase field: ready, charging, done, fault
// R16 - four-bit fault code encoding
// R17 - faults queued, read out one per read
// R18 - status at offset zero, guard enable resets zero
// R19 - overvoltage removal clears code without host; an unread queued code 1 stays in the status byte until a status read pops it
// R20 - event pulse counted in clocks, never shortened
// R21 - writes to read-only status bits ignored
package cfs_pkg;
  localparam int CLK_MHZ      = 125;
  localparam int PULSE_US     = 256;
  localparam int PULSE_CYC    = PULSE_US * CLK_MHZ;
  localparam int MS_CYC       = CLK_MHZ * 1000;
  localparam int WD_S         = 15;
  localparam int WD_MS        = WD_S * 1000;
  localparam int QDEPTH       = 16;

  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_TIMER  = 8'h05;
  // bus address value is arbitrary
  localparam logic [6:0] DEV_ADDR   = 7'h4b;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] MSB_BIT    = 4'h7;
  localparam int B_GUARD            = 6;
  localparam logic [1:0] SEL_RST    = 2'h1;

  localparam logic [1:0] PH_READY = 2'h0;
  localparam logic [1:0] PH_CHG   = 2'h1;
  localparam logic [1:0] PH_DONE  = 2'h2;
  localparam logic [1:0] PH_FAULT = 2'h3;
  localparam logic [3:0] FC_NORMAL = 4'h0;

  // bit n of the fault vector reports code n+1
  typedef struct packed {
    logic ldo_short;
    logic chg_set_short;
    logic no_batt;
    logic timer;
    logic die_trip;
    logic batt_ovp;
    logic batt_temp;
    logic sleep;
    logic undervoltage_lockout;
    logic overvoltage_guard;
  } cfs_fault_s;

  typedef struct packed {
    logic       overvoltage_guard;
    logic       undervoltage_lockout;
    logic       sleep;
    logic       batt_temp;
    logic       batt_ovp;
    logic       no_batt;
    logic       chg_set_short;
    logic       ldo_short;
    logic       die_trip;
    logic       die_cool;
    logic       heat_limit;
    logic [2:0] heat_steps;
  } cfs_sense_s;

  typedef enum logic [3:0] {
    S_READY = 4'h1,
    S_CHG   = 4'h2,
    S_DONE  = 4'h4,
    S_FAULT = 4'h8
  } cfs_chg_e;

  typedef enum logic [4:0] {
    I_IDLE = 5'h01,
    I_ADDR = 5'h02,
    I_PTR  = 5'h04,
    I_WR   = 5'h08,
    I_RD   = 5'h10
  } cfs_bus_e;
endpackage

// [cfs_charge_fault_supervisor.sv]
`timescale 1ns/1ps
module cfs_charge_fault_supervisor #(
  parameter int MS_CYC    = cfs_pkg::MS_CYC,
  parameter int WD_MS     = cfs_pkg::WD_MS,
  parameter int PULSE_CYC = cfs_pkg::PULSE_CYC,
  parameter int SAFE_MS0  = 3600000,
  parameter int SAFE_MS1  = 7200000,
  parameter int SAFE_MS2  = 14400000,
  parameter int SAFE_MS3  = 28800000
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // serial bus pins, open drain
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // analog sense and charge controller
  input  wire cfs_pkg::cfs_sense_s sense,
  input  wire logic               charge_req,
  input  wire logic               charge_term,
  // charger actions
  output logic                    system_rail_en,
  output logic                    charge_en,
  output logic [2:0]              charge_current_cut,
  output logic                    fallback_mode,
  output logic                    stat_pulse,
  output logic                    int_pulse
);
  function automatic logic [3:0] lowest_code(input logic [9:0] v);
    logic [3:0] c;
    c = cfs_pkg::FC_NORMAL;
    for (int i = 9; i >= 0; i--) begin
      if (v[i]) c = 4'(i + 1);
    end
    return c;
  endfunction

  // bus front end
  logic scl_q, sda_q;
  cfs_pkg::cfs_bus_e ist;
  logic [3:0] bit_cnt;
  logic [7:0] rx, tx, ptr, rd_data, status_byte;
  logic       ack_ph;
  wire i2c_start = scl_in & scl_q & sda_q & ~sda_in;
  wire i2c_stop  = scl_in & scl_q & ~sda_q & sda_in;
  wire scl_rise  = scl_in & ~scl_q;
  wire scl_fall  = ~scl_in & scl_q;
  wire byte_done = (bit_cnt == cfs_pkg::BYTE_BITS);
  wire addr_hit  = (rx[7:1] == cfs_pkg::DEV_ADDR);
  wire bus_live  = ~i2c_start & ~i2c_stop & (ist != cfs_pkg::I_IDLE);
  wire end_byte  = bus_live & scl_fall & byte_done & ~ack_ph;
  wire end_ack   = bus_live & scl_fall & ack_ph;
  wire wr_strobe = end_byte & (ist == cfs_pkg::I_WR);
  wire rd_load   = end_ack & (ist == cfs_pkg::I_RD);
  wire ack_byte  = (ist == cfs_pkg::I_ADDR) ? addr_hit : (ist != cfs_pkg::I_RD);
  cfs_pkg::cfs_bus_e ist_after;
  assign ist_after = (ist == cfs_pkg::I_ADDR) ?
                     (addr_hit ? (rx[0] ? cfs_pkg::I_RD : cfs_pkg::I_PTR) : cfs_pkg::I_IDLE) :
                     (ist == cfs_pkg::I_PTR) ? cfs_pkg::I_WR : ist;
  assign sda_out = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      ist     <= cfs_pkg::I_IDLE;
      bit_cnt <= 4'h0;
      rx      <= 8'h00;
      tx      <= 8'h00;
      ptr     <= 8'h00;
      ack_ph  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (i2c_start) begin
        ist     <= cfs_pkg::I_ADDR;
        bit_cnt <= 4'h0;
        ack_ph  <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (i2c_stop) begin
        ist    <= cfs_pkg::I_IDLE;
        ack_ph <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_live) begin
        if (scl_rise && !ack_ph && !byte_done) begin
          rx      <= {rx[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'h1;
        end
        // master nack ends a read burst
        if (scl_rise && ack_ph && ist == cfs_pkg::I_RD && sda_in) begin
          ist <= cfs_pkg::I_IDLE;
        end
        if (end_byte) begin
          ack_ph <= 1'b1;
          sda_oe <= ack_byte;
          ist    <= ist_after;
          if (ist == cfs_pkg::I_PTR) begin
            ptr <= rx;
          end else if (ist != cfs_pkg::I_ADDR) begin
            ptr <= ptr + 8'h01;
          end
        end else if (end_ack) begin
          ack_ph  <= 1'b0;
          bit_cnt <= 4'h0;
          sda_oe  <= rd_load & ~rd_data[7];
          if (rd_load) tx <= rd_data;
        end else if (scl_fall && ist == cfs_pkg::I_RD) begin
          sda_oe <= ~tx[3'(cfs_pkg::MSB_BIT - bit_cnt)];
        end
      end
    end
  end

  // shared millisecond tick for both timers
  logic [16:0] ms_cnt;
  wire ms_tick = (ms_cnt == 17'(MS_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ms_cnt <= 17'h0;
    else ms_cnt <= ms_tick ? 17'h0 : ms_cnt + 17'h1;
  end

  // fault picture
  logic tsd, safety_expired;
  cfs_pkg::cfs_chg_e st, next_st;
  cfs_pkg::cfs_fault_s fv;
  assign fv = {sense.ldo_short, sense.chg_set_short, sense.no_batt, safety_expired, tsd,
               sense.batt_ovp, sense.batt_temp, sense.sleep, sense.undervoltage_lockout, sense.overvoltage_guard};
  wire rail_off = sense.overvoltage_guard | sense.undervoltage_lockout | sense.sleep | tsd | sense.ldo_short; // see R01
  wire charge_block = rail_off | sense.batt_temp | sense.batt_ovp | safety_expired
                      | sense.no_batt | sense.chg_set_short; // see R02

  always_comb begin
    next_st = st;
    case (st)
      cfs_pkg::S_READY: begin
        if (charge_block) next_st = cfs_pkg::S_FAULT;
        else if (charge_req) next_st = cfs_pkg::S_CHG;
      end
      cfs_pkg::S_CHG: begin
        if (charge_block) next_st = cfs_pkg::S_FAULT;
        else if (charge_term) next_st = cfs_pkg::S_DONE;
      end
      cfs_pkg::S_DONE: begin
        if (charge_block) next_st = cfs_pkg::S_FAULT;
        else if (!charge_req) next_st = cfs_pkg::S_READY;
      end
      default: begin
        // cooled trip or cleared overvoltage re-enters a cycle unaided
        if (!charge_block) next_st = cfs_pkg::S_READY; // see R13 see R19
      end
    endcase
  end

  // safety timer
  logic [1:0]  timer_sel;
  logic [31:0] safe_cnt, safe_lim;
  assign safe_lim = (timer_sel == 2'h0) ? 32'(SAFE_MS0) :
                    (timer_sel == 2'h1) ? 32'(SAFE_MS1) :
                    (timer_sel == 2'h2) ? 32'(SAFE_MS2) : 32'(SAFE_MS3); // see R06
  wire safe_run = (st == cfs_pkg::S_CHG) & ~charge_block; // see R04
  wire safe_hit = safe_run & ms_tick & (safe_cnt >= safe_lim - 32'h1);
  wire safe_clr = sense.undervoltage_lockout | safe_hit | ((st == cfs_pkg::S_CHG) & charge_term); // see R03

  // watchdog
  logic        host_guard_enable, timeout_flag;
  logic [13:0] wd_cnt;
  wire wd_run = host_guard_enable & ~fallback_mode & ~tsd; // see R12
  wire wd_hit = wd_run & ms_tick & (wd_cnt == 14'(WD_MS - 1));
  wire st_wr  = wr_strobe & (ptr == cfs_pkg::REG_STATUS);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st             <= cfs_pkg::S_READY;
      tsd            <= 1'b0;
      safety_expired <= 1'b0;
      safe_cnt       <= 32'h0;
      timer_sel      <= cfs_pkg::SEL_RST;
      wd_cnt         <= 14'h0;
      host_guard_enable <= 1'b0;
      timeout_flag   <= 1'b0;
      fallback_mode  <= 1'b1;
    end else begin
      st <= next_st;
      if (sense.die_trip) tsd <= 1'b1;
      else if (sense.die_cool) tsd <= 1'b0;
      if (safe_hit) safety_expired <= 1'b1; // see R05
      else if (sense.undervoltage_lockout) safety_expired <= 1'b0;
      if (safe_clr) safe_cnt <= 32'h0;
      else if (safe_run && ms_tick) safe_cnt <= safe_cnt + 32'h1;
      // only the guard enable bit of the status byte is writable
      if (st_wr) host_guard_enable <= rx[cfs_pkg::B_GUARD]; // see R08 see R21
      if (wd_hit) timer_sel <= cfs_pkg::SEL_RST; // see R09
      else if (wr_strobe && ptr == cfs_pkg::REG_TIMER) timer_sel <= rx[1:0];
      if (wr_strobe) wd_cnt <= 14'h0; // see R07
      else if (wd_run && ms_tick) wd_cnt <= wd_hit ? 14'h0 : wd_cnt + 14'h1;
      if (wd_hit) timeout_flag <= 1'b1; // see R14
      if (wd_hit) fallback_mode <= 1'b1;
      else if (wr_strobe && !safety_expired) fallback_mode <= 1'b0; // see R10
    end
  end

  // fault queue: each newly risen fault is logged once per occurrence, unless it clears while the queue is full
  logic [3:0] q_mem [cfs_pkg::QDEPTH];
  logic [3:0] q_wp, q_rp;
  logic [4:0] q_cnt;
  logic [9:0] seen;
  wire [9:0] pending   = fv & ~seen;
  wire       q_full    = (q_cnt == 5'(cfs_pkg::QDEPTH));
  wire       push      = (|pending) & ~q_full;
  wire [3:0] push_code = lowest_code(pending);
  wire       pop       = rd_load & (ptr == cfs_pkg::REG_STATUS) & (q_cnt != 5'h0); // see R17
  wire [3:0] code_now  = (q_cnt != 5'h0) ? q_mem[q_rp] : lowest_code(fv); // see R16
  logic [1:0] phase;
  assign phase = (st == cfs_pkg::S_FAULT) ? cfs_pkg::PH_FAULT :
                 (st == cfs_pkg::S_CHG)   ? cfs_pkg::PH_CHG :
                 (st == cfs_pkg::S_DONE)  ? cfs_pkg::PH_DONE : cfs_pkg::PH_READY; // see R15
  assign status_byte = {timeout_flag, host_guard_enable, phase, code_now}; // see R18
  assign rd_data = (ptr == cfs_pkg::REG_STATUS) ? status_byte :
                   (ptr == cfs_pkg::REG_TIMER)  ? {6'h00, timer_sel} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (push) q_mem[q_wp] <= push_code;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_wp  <= 4'h0;
      q_rp  <= 4'h0;
      q_cnt <= 5'h0;
      seen  <= 10'h0;
    end else begin
      if (push) q_wp <= q_wp + 4'h1;
      if (pop) q_rp <= q_rp + 4'h1;
      q_cnt <= q_cnt + 5'(push) - 5'(pop);
      seen  <= (seen & fv) | (push ? 10'(10'h1 << (push_code - 4'h1)) : 10'h0);
    end
  end

  // event pulse; a busy pulse is not retriggered so it never shortens
  logic [14:0] pulse_cnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt          <= 15'h0;
      stat_pulse         <= 1'b0;
      int_pulse          <= 1'b0;
      system_rail_en     <= 1'b0;
      charge_en          <= 1'b0;
      charge_current_cut <= 3'h0;
    end else begin
      if (!stat_pulse && push) begin
        pulse_cnt  <= 15'(PULSE_CYC - 1); // see R20
        stat_pulse <= 1'b1;
        int_pulse  <= 1'b1;
      end else if (stat_pulse) begin
        pulse_cnt  <= pulse_cnt - 15'h1;
        stat_pulse <= (pulse_cnt != 15'h0);
        int_pulse  <= (pulse_cnt != 15'h0);
      end
      system_rail_en <= ~rail_off;
      // expiry drops charging on the very edge that latches it
      charge_en      <= (next_st == cfs_pkg::S_CHG) & ~charge_block & ~safe_hit; // see R05
      charge_current_cut <= (safe_run && sense.heat_limit) ? sense.heat_steps : 3'h0; // see R11
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_guard_off;
    st_wr && !rx[cfs_pkg::B_GUARD];
  endsequence
  sequence s_trip_rise;
    $rose(tsd);
  endsequence

  a_rail_cut_both:   assert property (rail_off |=> !system_rail_en && !charge_en) // see R01
    else $error("rail or charge left on during input fault");
  a_rail_kept_on:    assert property (!rail_off && sense.batt_temp |=> // see R02
                                      system_rail_en && !charge_en)
    else $error("battery fault handling wrong");
  a_timer_clear:     assert property (sense.undervoltage_lockout |=> safe_cnt == 32'h0) // see R03
    else $error("safety timer not cleared");
  a_timer_suspend:   assert property (charge_block && !safe_clr |=> $stable(safe_cnt)) // see R01
    else $error("safety timer moved while suspended");
  a_expiry_block:    assert property (safe_hit |=> // see R05 see R10
                                      safety_expired && !charge_en ##1 !charge_en)
    else $error("charging after safety expiry");
  a_wd_restart_wr:   assert property (wr_strobe |=> wd_cnt == 14'h0) // see R07
    else $error("watchdog not restarted by write");
  a_wd_guard_off:    assert property (s_guard_off |=> // see R08
                                      !host_guard_enable ##1 $stable(wd_cnt))
    else $error("watchdog still running when disabled");
  a_wd_fallback:     assert property (wd_hit |=> timeout_flag && fallback_mode) // see R09 see R14
    else $error("watchdog expiry not handled");
  a_trip_pulse:      assert property (s_trip_rise |-> ##[1:3] stat_pulse && int_pulse) // see R12
    else $error("no pulse on thermal trip");
  a_pulse_start:     assert property ($rose(stat_pulse) |-> pulse_cnt == 15'(PULSE_CYC - 1)) // see R20
    else $error("pulse length wrong");
  a_pulse_hold:      assert property (stat_pulse && pulse_cnt != 15'h0 |=> stat_pulse) // see R20
    else $error("pulse shortened");
  a_timer_count:     assert property (safe_run && ms_tick && !safe_clr |=> // see R04
                                      safe_cnt == $past(safe_cnt) + 32'h1)
    else $error("safety timer did not advance");
  a_guard_restart:   assert property (st_wr && rx[cfs_pkg::B_GUARD] |=> // see R08
                                      host_guard_enable && wd_cnt == 14'h0)
    else $error("watchdog not restarted by enable");
endmodule

// [cfs_i2c_host.sv]
`timescale 1ns/1ps
module cfs_i2c_host #(
  parameter int HALF = 4
) (
  // clock
  input  wire logic sys_clk,
  // bus lines, open drain with pull-ups
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic half_bit();
    repeat (HALF) @(negedge sys_clk);
  endtask

  // data is sampled late in the high phase, well after the device moves it
  task automatic clock_pulse(output logic seen);
    half_bit();
    scl = 1'b1;
    half_bit();
    seen = sda;
    scl = 1'b0;
  endtask

  // also serves as repeated start: scl rises only after sda is released
  task automatic start_cond();
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_drv = 1'b0;
    half_bit();
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_drv = 1'b1;
    half_bit();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      clock_pulse(seen);
    end
    sda_drv = 1'b1;
    clock_pulse(seen);
    ack = ~seen;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic seen;
    sda_drv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      clock_pulse(seen);
      b[i] = seen;
    end
    sda_drv = last;
    clock_pulse(seen);
  endtask

  // each write also returns the device to host control, unless the safety timer has expired
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({cfs_pkg::DEV_ADDR, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(data, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // second byte comes from the next offset, so the first one is always acked
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
    logic       a0, a1, a2;
    logic [7:0] spare;
    start_cond();
    send_byte({cfs_pkg::DEV_ADDR, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({cfs_pkg::DEV_ADDR, 1'b1}, a2);
    recv_byte(1'b0, data);
    recv_byte(1'b1, spare);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

// [tb_cfs_charge_fault_supervisor.sv]
`timescale 1ns/1ps
module tb_cfs_charge_fault_supervisor;
  localparam int MS    = 10;
  localparam int WDMS  = 40;
  localparam int PULSE = 8;
  localparam int SAFE0 = 20;
  localparam logic [3:0] CODES [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};

  logic                sys_clk = 1'b0;
  logic                rst_n   = 1'b0;
  logic                scl;
  logic                host_sda;
  wire logic           sda;
  logic                sda_out;
  logic                sda_oe;
  cfs_pkg::cfs_sense_s sense   = '0;
  logic                charge_req  = 1'b0;
  logic                charge_term = 1'b0;
  logic                system_rail_en;
  logic                charge_en;
  logic [2:0]          charge_current_cut;
  logic                fallback_mode;
  logic                stat_pulse;
  logic                int_pulse;
  int                  n_errors = 0;
  int                  n_tests  = 0;
  int                  n;
  logic [3:0]          fc;
  logic                rail;

  always #4 sys_clk = ~sys_clk;
  // device pulls the line to what it drives only while enabled, pull-up otherwise
  assign sda = host_sda & (sda_oe ? sda_out : 1'b1);

  cfs_charge_fault_supervisor #(
    .MS_CYC(MS), .WD_MS(WDMS), .PULSE_CYC(PULSE),
    .SAFE_MS0(SAFE0), .SAFE_MS1(9000), .SAFE_MS2(30), .SAFE_MS3(40)
  ) i_cfs_charge_fault_supervisor (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sense(sense), .charge_req(charge_req),
    .charge_term(charge_term), .system_rail_en(system_rail_en), .charge_en(charge_en),
    .charge_current_cut(charge_current_cut), .fallback_mode(fallback_mode),
    .stat_pulse(stat_pulse), .int_pulse(int_pulse)
  );

  cfs_i2c_host i_cfs_i2c_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(host_sda));

  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    i_cfs_i2c_host.write_reg(ptr, data, ok);
    check({7'h0, ok}, 8'h01, "write ack");
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] d;
    logic       ok;
    i_cfs_i2c_host.read_reg(ptr, d, ok);
    check({7'h0, ok}, 8'h01, "read ack");
    check(d & mask, exp & mask, "read data");
  endtask

  task automatic acts(input logic [1:0] exp);
    check({6'h0, system_rail_en, charge_en}, {6'h0, exp}, "rail and charge");
  endtask

  // pulse must appear promptly and last exactly its count on stat_pulse, with int_pulse high throughout
  task automatic pulse_check();
    int k;
    k = 0;
    while (stat_pulse !== 1'b1 && k < 6) begin
      cyc(1);
      k++;
    end
    k = 0;
    while (stat_pulse === 1'b1 && k < 40) begin
      check({7'h0, int_pulse}, 8'h01, "int pulse");
      cyc(1);
      k++;
    end
    check(8'(k), 8'(PULSE), "pulse length");
  endtask

  task automatic set_fault(input logic [3:0] c, input logic v);
    case (c)
      4'h1: sense.overvoltage_guard = v;
      4'h2: sense.undervoltage_lockout = v;
      4'h3: sense.sleep = v;
      4'h4: sense.batt_temp = v;
      4'h5: sense.batt_ovp = v;
      4'h6: sense.die_trip = v;
      4'h8: sense.no_batt = v;
      4'h9: sense.chg_set_short = v;
      default: sense.ldo_short = v;
    endcase
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    check({7'h0, fallback_mode}, 8'h01, "fallback at reset");
    acts(2'b10);
    rd(cfs_pkg::REG_STATUS, 8'h00, 8'hff);
    rd(8'h01, 8'h00, 8'hff);
    charge_req = 1'b1;
    cyc(4);
    acts(2'b11);
    for (int k = 0; k < 9; k++) begin
      fc   = CODES[k];
      rail = !(fc inside {4'h1, 4'h2, 4'h3, 4'h6, 4'ha});
      set_fault(fc, 1'b1);
      pulse_check();
      acts({rail, 1'b0});
      rd(cfs_pkg::REG_STATUS, {2'b00, cfs_pkg::PH_FAULT, fc}, 8'hff);
      set_fault(fc, 1'b0);
      if (fc == 4'h6) begin
        cyc(4);
        acts(2'b00);
        sense.die_cool = 1'b1;
        cyc(4);
        sense.die_cool = 1'b0;
      end
      cyc(4);
      acts(2'b11);
      rd(cfs_pkg::REG_STATUS, {2'b00, cfs_pkg::PH_CHG, 4'h0}, 8'hff);
    end
    sense.batt_temp = 1'b1;
    sense.no_batt   = 1'b1;
    pulse_check();
    rd(cfs_pkg::REG_STATUS, 8'h04, 8'h0f);
    rd(cfs_pkg::REG_STATUS, 8'h08, 8'h0f);
    rd(cfs_pkg::REG_STATUS, 8'h04, 8'h0f);
    sense.batt_temp = 1'b0;
    sense.no_batt   = 1'b0;
    cyc(4);
    rd(cfs_pkg::REG_STATUS, {2'b00, cfs_pkg::PH_CHG, 4'h0}, 8'hff);
    // short timer selected while undervoltage holds the timer at zero
    sense.undervoltage_lockout = 1'b1;
    wr(cfs_pkg::REG_TIMER, 8'h00);
    sense.undervoltage_lockout = 1'b0;
    cyc(4);
    acts(2'b11);
    n = 0;
    while (charge_en === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check({7'h0, n >= SAFE0 * MS - 20 && n <= SAFE0 * MS + 15}, 8'h01, "timer span");
    pulse_check();
    acts(2'b10);
    rd(cfs_pkg::REG_STATUS, 8'h02, 8'h0f);
    rd(cfs_pkg::REG_STATUS, {2'b00, cfs_pkg::PH_FAULT, 4'h7}, 8'hff);
    wr(cfs_pkg::REG_TIMER, 8'h01);
    cyc(20);
    acts(2'b10);
    sense.undervoltage_lockout = 1'b1;
    cyc(4);
    sense.undervoltage_lockout = 1'b0;
    cyc(4);
    acts(2'b11);
    rd(cfs_pkg::REG_STATUS, 8'h02, 8'h0f);
    wr(cfs_pkg::REG_STATUS, 8'h40);
    cyc(100);
    wr(cfs_pkg::REG_TIMER, 8'h01);
    cyc(300);
    check({7'h0, fallback_mode}, 8'h00, "host mode kept");
    cyc(150);
    check({6'h0, fallback_mode, charge_en}, 8'h03, "fallback");
    rd(cfs_pkg::REG_STATUS, 8'hc0, 8'hc0);
    wr(cfs_pkg::REG_STATUS, 8'h3f);
    cyc(500);
    check({7'h0, fallback_mode}, 8'h00, "guard stopped");
    rd(cfs_pkg::REG_STATUS, {2'b10, cfs_pkg::PH_CHG, 4'h0}, 8'hff);
    sense.heat_limit = 1'b1;
    sense.heat_steps = 3'h5;
    cyc(4);
    check({5'h0, charge_current_cut}, 8'h05, "taper");
    sense.heat_limit = 1'b0;
    cyc(4);
    check({5'h0, charge_current_cut}, 8'h00, "no taper");
    charge_term = 1'b1;
    cyc(4);
    rd(cfs_pkg::REG_STATUS, {2'b00, cfs_pkg::PH_DONE, 4'h0}, 8'h30);
    charge_term = 1'b0;
    end_of_test();
  end
endmodule
